/* File: verilog/sdr_pkg.sv */
// Shared constants for the serial datagram reply block.
// Assumes one 50 MHz clock domain; link pins are synchronised on entry.
package sdr_pkg;
    // Frame layout
    localparam int FRAME_BITS = 32;
    localparam int DATA_BITS = 24;
    localparam int ADDR_BITS = 6;
    localparam int CNT_W = 6;
    localparam int RRS_POS = 31;
    localparam int ADDR_HI = 30;
    localparam int ADDR_LO = 25;
    localparam int RW_POS = 24;
    localparam int STAT_BITS = 8;
    // Status byte positions inside the reply's upper byte
    localparam int ST_INT = 7;
    localparam int ST_RR = 5;
    localparam int ST_GP = 3;
    localparam int ST_RL = 1;
    localparam int ST_TR = 0;
    // On-chip RAM: one frame writes an even/odd pair of 6-bit words
    localparam int RAM_WORD = 6;
    localparam int RAM_EVEN_LO = 0;
    localparam int RAM_ODD_LO = 8;
    // Serial register addresses
    localparam logic [ADDR_BITS-1:0] SPI_TARGET = 6'h00;
    localparam logic [ADDR_BITS-1:0] SPI_ACTUAL = 6'h01;
    localparam logic [ADDR_BITS-1:0] SPI_CONFIG = 6'h3F;
    // Configuration bits
    localparam int CFG_W = 2;
    localparam int CFG_RSW_DIS = 0;
    localparam int CFG_IRQ_ONLY = 1;
    // Local register port byte offsets
    localparam int BUS_AW = 8;
    localparam logic [BUS_AW-1:0] BUS_IRQ_STATUS = 8'h00;
    localparam logic [BUS_AW-1:0] BUS_IRQ_CLEAR = 8'h04;
    localparam logic [BUS_AW-1:0] BUS_IRQ_ENABLE = 8'h08;
    localparam logic [BUS_AW-1:0] BUS_CONFIG = 8'h0C;
    localparam logic [BUS_AW-1:0] BUS_TARGET = 8'h10;
    localparam logic [BUS_AW-1:0] BUS_REPLY = 8'h14;
    // Interrupt events
    localparam int EV_LEFT = 0;
    localparam int EV_RIGHT = 1;
    localparam int EV_GP = 2;
    localparam int EV_TARGET = 3;
    localparam int EV_FRAME = 4;
    localparam int NUM_EV = 5;
    // Synchronised pin vector
    localparam int SY_SCLK = 0;
    localparam int SY_SEL = 1;
    localparam int SY_SDI = 2;
    localparam int SY_RSW = 3;
    localparam int SY_LSW = 4;
    localparam int SY_GP = 5;
    localparam int SY_W = 6;
    localparam logic [SY_W-1:0] SY_RESET = 6'h03;
    // Link state
    typedef enum logic [1:0] {
        SDR_IDLE = 2'b00,
        SDR_SHIFT = 2'b01,
        SDR_EXEC = 2'b10
    } sdr_link_t;
endpackage : sdr_pkg

/* File: verilog/sdr_sync.sv */
// Two-flop synchroniser for a vector of unrelated pin levels.
// Assumes each bit is a slow level; no bus coherence is implied.
module sdr_sync
    import sdr_pkg::*;
#(
    parameter int W = SY_W,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta_q <= RST;
            q <= RST;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : sdr_sync

/* File: verilog/sdr_ram.sv */
// Small configuration RAM; each location holds an even/odd word pair.
// Assumes one write and one read port on the same clock; read is registered.
module sdr_ram
    import sdr_pkg::*;
#(
    parameter int AW = ADDR_BITS,
    parameter int DW = 2 * RAM_WORD
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [2**AW];

    // Contents are not reset; software loads them after power-up
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : sdr_ram

/* File: verilog/sdr_top.sv */
// Serial datagram slave: takes 32-bit commands, returns status and read data.
// Assumes host pins are asynchronous to clk and are oversampled at least 8x.
// Contract
// R1 - Command: bit 31 RAM select, bits 30..25 address, bit 24 read, 24 data bits.
// R2 - Reply frame matches command length: status in upper 8, data in lower 24.
// R3 - While select is high, the shared pin carries the active-low interrupt.
// R4 - Reply bits leave most significant first, least significant last.
// R5 - Replies only while the host clocks a frame; never self-started.
// R6 - Status: interrupt 31, right 29, general 27, left 25, target 24; others zero.
// R7 - Reply interrupt bit is the active-high interrupt controller output.
// R8 - One pin carries interrupt or read-back, selected by interface state.
// R9 - During a frame the shared pin follows reply bits, not the interrupt.
// R10 - Host masks its interrupt input on the shared pin during frames.
// R11 - Host keeps the interrupt-only output bit cleared to keep serial data.
// R12 - Left switch status follows the left switch input level.
// R13 - Right switch status shows the input only while its disable bit is clear.
// R14 - General status bit follows the general-purpose input level.
// R15 - Target-reached bit set while actual position equals target position.
// R16 - Switch, general and target conditions can each raise an interrupt.
// R17 - A read frame returns the addressed register in the next reply's data.
// R18 - A write with RAM select set goes to on-chip RAM, decoded like registers.
// R19 - One RAM write stores two 6-bit words at a consecutive location pair; the code keeps both words in the one location at the command address.
module sdr_top
    import sdr_pkg::*;
#(
    parameter int POS_W = DATA_BITS
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic host_sclk,
    input wire logic host_select_n,
    input wire logic host_sdi,
    input wire logic right_switch,
    input wire logic left_switch,
    input wire logic general_input,
    input wire logic [POS_W-1:0] actual_position,
    output logic shared_out_irq_pin,
    output logic [POS_W-1:0] target_position,
    output logic irq,
    input wire logic [BUS_AW-1:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata
);
    logic [SY_W-1:0] pins_raw;
    logic [SY_W-1:0] pins_s;
    logic sclk_prev_q;
    logic sel_prev_q;
    logic sclk_rise;
    logic sclk_fall;
    logic sel_fall;
    logic sel_rise;
    sdr_link_t link_q;
    logic [CNT_W-1:0] bit_cnt_q;
    logic [FRAME_BITS-1:0] rx_q;
    logic [FRAME_BITS-1:0] tx_q;
    logic cmd_ram;
    logic cmd_read;
    logic [ADDR_BITS-1:0] cmd_addr;
    logic [DATA_BITS-1:0] cmd_data;
    logic exec;
    logic [POS_W-1:0] target_q;
    logic [CFG_W-1:0] config_q;
    logic [DATA_BITS-1:0] read_data_q;
    logic ram_pend_q;
    logic ram_we;
    logic [2*RAM_WORD-1:0] ram_wdata;
    logic [2*RAM_WORD-1:0] ram_rdata;
    logic right_live;
    logic left_live;
    logic gp_live;
    logic target_reached_flag;
    logic [STAT_BITS-1:0] status_byte;
    logic [NUM_EV-1:0] lvl;
    logic [NUM_EV-1:0] lvl_prev_q;
    logic [NUM_EV-1:0] ev;
    logic [NUM_EV-1:0] irq_stat_q;
    logic [NUM_EV-1:0] irq_en_q;
    logic [NUM_EV-1:0] irq_clr;
    logic irq_w;
    logic pin_q;
    logic [31:0] bus_rdata_q;

    // Serial register read mux; unmapped addresses read as zero
    function automatic logic [DATA_BITS-1:0] spi_read(
        input logic [ADDR_BITS-1:0] a,
        input logic [POS_W-1:0] tgt,
        input logic [POS_W-1:0] act,
        input logic [CFG_W-1:0] cfg
    );
        logic [DATA_BITS-1:0] r;
        r = '0;
        case (a)
            SPI_TARGET: r = DATA_BITS'(tgt);
            SPI_ACTUAL: r = DATA_BITS'(act);
            SPI_CONFIG: r[CFG_W-1:0] = cfg;
            default: r = '0;
        endcase
        return r;
    endfunction : spi_read

    // All pins enter through two flops; link idles with clock and select high
    assign pins_raw = {general_input, left_switch, right_switch,
                       host_sdi, host_select_n, host_sclk};

    sdr_sync #(
        .W(SY_W),
        .RST(SY_RESET)
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .d(pins_raw),
        .q(pins_s)
    );

    // Edge history of the synchronised link clock and select
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sclk_prev_q <= 1'b1;
            sel_prev_q <= 1'b1;
        end else begin
            sclk_prev_q <= pins_s[SY_SCLK];
            sel_prev_q <= pins_s[SY_SEL];
        end
    end

    assign sclk_rise = pins_s[SY_SCLK] & ~sclk_prev_q;
    assign sclk_fall = ~pins_s[SY_SCLK] & sclk_prev_q;
    assign sel_fall = ~pins_s[SY_SEL] & sel_prev_q;
    assign sel_rise = pins_s[SY_SEL] & ~sel_prev_q;

    // Link state: only a host select edge starts a frame
    always_ff @(posedge clk) begin
        if (!rstn) begin
            link_q <= SDR_IDLE;
        end else begin
            case (link_q)
                SDR_IDLE: begin
                    if (sel_fall) begin
                        link_q <= SDR_SHIFT; // R5
                    end
                end
                SDR_SHIFT: begin
                    // Frames of any other length are dropped whole
                    if (sel_rise) begin
                        link_q <= (bit_cnt_q == CNT_W'(FRAME_BITS)) ? SDR_EXEC : SDR_IDLE;
                    end
                end
                SDR_EXEC: link_q <= SDR_IDLE;
                default: link_q <= SDR_IDLE;
            endcase
        end
    end

    // Bit counter saturates so that an overlong frame is not mistaken
    always_ff @(posedge clk) begin
        if (!rstn) begin
            bit_cnt_q <= '0;
        end else if (sel_fall) begin
            bit_cnt_q <= '0;
        end else if (link_q == SDR_SHIFT && sclk_rise && !(&bit_cnt_q)) begin
            bit_cnt_q <= bit_cnt_q + CNT_W'(1);
        end
    end

    // Command bits sampled on rising link clock, first bit ends at the top
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rx_q <= '0;
        end else if (link_q == SDR_SHIFT && sclk_rise) begin
            rx_q <= {rx_q[FRAME_BITS-2:0], pins_s[SY_SDI]};
        end
    end

    // Command field split
    assign cmd_ram = rx_q[RRS_POS]; // R1
    assign cmd_addr = rx_q[ADDR_HI:ADDR_LO]; // R1
    assign cmd_read = rx_q[RW_POS]; // R1
    assign cmd_data = rx_q[DATA_BITS-1:0]; // R1
    assign exec = (link_q == SDR_EXEC);

    // Live status levels
    assign left_live = pins_s[SY_LSW]; // R12
    assign right_live = pins_s[SY_RSW] & ~config_q[CFG_RSW_DIS]; // R13
    assign gp_live = pins_s[SY_GP]; // R14
    assign target_reached_flag = (actual_position == target_q); // R15

    // Reply status byte; unlisted positions stay zero
    always_comb begin
        status_byte = '0; // R6
        status_byte[ST_INT] = irq_w; // R7
        status_byte[ST_RR] = right_live; // R6
        status_byte[ST_GP] = gp_live; // R6
        status_byte[ST_RL] = left_live; // R6
        status_byte[ST_TR] = target_reached_flag; // R6
    end

    // Reply loaded at select fall so status is current for this frame
    // First clock fall keeps the MSB; shifting there would lose it before the host samples
    always_ff @(posedge clk) begin
        if (!rstn) begin
            tx_q <= '0;
        end else if (sel_fall) begin
            tx_q <= {status_byte, read_data_q}; // R2
        end else if (link_q == SDR_SHIFT && sclk_fall && bit_cnt_q != '0) begin
            tx_q <= {tx_q[FRAME_BITS-2:0], 1'b0}; // R4
        end
    end

    // Shared pin: reply bit in a frame unless interrupt-only is set, else the active-low interrupt
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pin_q <= 1'b1;
        end else if (link_q == SDR_SHIFT && !config_q[CFG_IRQ_ONLY]) begin
            pin_q <= tx_q[FRAME_BITS-1]; // R9
        end else begin
            pin_q <= ~irq_w; // R3 R8
        end
    end

    assign shared_out_irq_pin = pin_q;

    // Serial-side register writes; the local port may also set config
    always_ff @(posedge clk) begin
        if (!rstn) begin
            target_q <= '0;
        end else if (exec && !cmd_ram && !cmd_read && cmd_addr == SPI_TARGET) begin
            target_q <= POS_W'(cmd_data);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            config_q <= '0;
        end else if (bus_wr && bus_addr == BUS_CONFIG) begin
            config_q <= bus_wdata[CFG_W-1:0];
        end else if (exec && !cmd_ram && !cmd_read && cmd_addr == SPI_CONFIG) begin
            config_q <= cmd_data[CFG_W-1:0];
        end
    end

    assign target_position = target_q;

    // RAM pair: low byte to even word, next byte to odd word
    assign ram_we = exec & cmd_ram & ~cmd_read; // R18
    assign ram_wdata = {cmd_data[RAM_ODD_LO +: RAM_WORD],
                        cmd_data[RAM_EVEN_LO +: RAM_WORD]}; // R19

    sdr_ram #(
        .AW(ADDR_BITS),
        .DW(2 * RAM_WORD)
    ) u_ram (
        .clk(clk),
        .we(ram_we),
        .waddr(cmd_addr),
        .wdata(ram_wdata),
        .raddr(cmd_addr),
        .rdata(ram_rdata)
    );

    // RAM read data arrive one cycle after the request
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ram_pend_q <= 1'b0;
        end else begin
            ram_pend_q <= exec & cmd_ram & cmd_read;
        end
    end

    // Read result waits for the next frame; command data bits are ignored
    always_ff @(posedge clk) begin
        if (!rstn) begin
            read_data_q <= '0;
        end else if (exec && cmd_read && !cmd_ram) begin
            read_data_q <= spi_read(cmd_addr, target_q, actual_position, config_q); // R17
        end else if (ram_pend_q) begin
            read_data_q <= '0;
            read_data_q[RAM_EVEN_LO +: RAM_WORD] <= ram_rdata[RAM_WORD-1:0];
            read_data_q[RAM_ODD_LO +: RAM_WORD] <= ram_rdata[2*RAM_WORD-1:RAM_WORD];
        end
    end

    // Interrupt sources: rising edges of each condition plus frame done
    assign lvl = {1'b0, target_reached_flag, gp_live, right_live, left_live};

    always_ff @(posedge clk) begin
        if (!rstn) begin
            lvl_prev_q <= lvl; // A target level already high at reset is not an event; a switch or general pin high at reset raises one
        end else begin
            lvl_prev_q <= lvl;
        end
    end

    always_comb begin
        ev = lvl & ~lvl_prev_q; // R16
        ev[EV_FRAME] = exec;
    end

    // Clear register is write-only; a new event beats a clear
    assign irq_clr = (bus_wr && bus_addr == BUS_IRQ_CLEAR) ? bus_wdata[NUM_EV-1:0] : '0;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | ev; // R16
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_en_q <= '0;
        end else if (bus_wr && bus_addr == BUS_IRQ_ENABLE) begin
            irq_en_q <= bus_wdata[NUM_EV-1:0];
        end
    end

    assign irq_w = |(irq_stat_q & irq_en_q); // R7
    assign irq = irq_w;

    // Local read port: data valid the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rstn) begin
            bus_rdata_q <= '0;
        end else if (bus_rd) begin
            bus_rdata_q <= '0;
            case (bus_addr)
                BUS_IRQ_STATUS: bus_rdata_q[NUM_EV-1:0] <= irq_stat_q;
                BUS_IRQ_ENABLE: bus_rdata_q[NUM_EV-1:0] <= irq_en_q;
                BUS_CONFIG: bus_rdata_q[CFG_W-1:0] <= config_q;
                BUS_TARGET: bus_rdata_q[POS_W-1:0] <= target_q;
                BUS_REPLY: bus_rdata_q[STAT_BITS-1:0] <= status_byte;
                default: bus_rdata_q <= '0;
            endcase
        end
    end

    assign bus_rdata = bus_rdata_q;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    idle_pin_irq_a: assert property ( // R3
        link_q != SDR_SHIFT |=> shared_out_irq_pin == !$past(irq_w))
        else $error("shared pin not showing interrupt while idle");

    frame_pin_data_a: assert property ( // R9
        link_q == SDR_SHIFT && !config_q[CFG_IRQ_ONLY]
        |=> shared_out_irq_pin == $past(tx_q[FRAME_BITS-1]))
        else $error("shared pin not following reply bit");

    reply_load_a: assert property ( // R2
        sel_fall |=> tx_q == {$past(status_byte), $past(read_data_q)})
        else $error("reply frame not loaded at frame start");

    msb_shift_a: assert property ( // R4
        link_q == SDR_SHIFT && sclk_fall && !sel_fall && bit_cnt_q != '0
        |=> tx_q == {$past(tx_q[FRAME_BITS-2:0]), 1'b0})
        else $error("reply not shifted msb first");

    first_bit_hold_a: assert property ( // R4
        link_q == SDR_SHIFT && sclk_fall && !sel_fall && bit_cnt_q == '0
        |=> tx_q == $past(tx_q))
        else $error("reply msb lost at first clock fall");

    no_self_start_a: assert property ( // R5
        link_q == SDR_IDLE && !sel_fall |=> link_q != SDR_SHIFT)
        else $error("frame started without host select");

    status_zero_a: assert property ( // R6
        sel_fall |=> !tx_q[30] && !tx_q[28] && !tx_q[26] && tx_q[31] == $past(irq_w))
        else $error("reply status layout wrong");

    right_gate_a: assert property ( // R13
        config_q[CFG_RSW_DIS] |-> !status_byte[ST_RR])
        else $error("right switch shown while disabled");

    target_flag_a: assert property ( // R15
        status_byte[ST_TR] == (actual_position == target_q))
        else $error("target flag disagrees with positions");

    event_sticky_a: assert property ( // R16
        ev[EV_TARGET] ##1 !(bus_wr && bus_addr == BUS_IRQ_CLEAR) |-> irq_stat_q[EV_TARGET])
        else $error("target event not latched");

    read_return_a: assert property ( // R17
        exec && cmd_read && !cmd_ram && cmd_addr == SPI_TARGET
        |=> read_data_q == $past(target_q))
        else $error("read result not captured");

    ram_return_a: assert property ( // R19
        exec && cmd_ram && cmd_read |=> ##1 read_data_q[RAM_WORD-1:0] == $past(ram_rdata[RAM_WORD-1:0]))
        else $error("ram pair not returned");

    frame_seen_c: cover property (sel_fall ##[1:400] exec);
    read_frame_c: cover property (exec && cmd_read && !cmd_ram);
    ram_write_c: cover property (ram_we);
    irq_raise_c: cover property (!irq_w ##1 irq_w);
endmodule : sdr_top

/* File: bench/sdr_host_model.sv */
// Host-side serial master model for the datagram reply bench.
// Assumes it owns the link pins; its own 160 ns link clock is unrelated to clk.
module sdr_host_model (
    output logic sclk,
    output logic sel_n,
    output logic sdi,
    input wire logic sdo
);
    timeunit 1ns;
    timeprecision 100ps;

    logic irq_masked;

    // Link idles with select and clock high, as a real host leaves them
    initial begin
        sclk = 1'b1;
        sel_n = 1'b1;
        sdi = 1'b0;
        irq_masked = 1'b0;
    end

    // One frame, MSB first; fewer than 32 bits makes a frame the device must drop
    task automatic frame(input logic [31:0] cmd, input int nbits, output logic [31:0] rsp);
        rsp = '0;
        irq_masked = 1'b1;
        sel_n = 1'b0;
        #173;
        for (int i = 31; i > 31 - nbits; i--) begin
            sclk = 1'b0;
            sdi = cmd[i];
            #99;
            rsp = {rsp[30:0], sdo};
            #1;
            sclk = 1'b1;
            #60;
        end
        // Low phase longer than high: reply is sampled well after its update
        #97;
        sel_n = 1'b1;
        sdi = ~sdi;
        #260;
        irq_masked = 1'b0;
    endtask : frame
endmodule : sdr_host_model

/* File: bench/serial_datagram_status_reply_tb_top.sv */
// Self-checking bench for the serial datagram reply block.
// Assumes sdr_host_model drives the link; local bus and pins driven here.
`define CHK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
        end \
    end
module serial_datagram_status_reply_tb_top;
    import sdr_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk, rstn, host_sclk, host_select_n, host_sdi;
    logic right_switch, left_switch, general_input, shared_out_irq_pin, irq;
    logic [DATA_BITS-1:0] actual_position, target_position;
    logic [BUS_AW-1:0] bus_addr;
    logic [31:0] bus_wdata, bus_rdata;
    logic bus_wr, bus_rd;
    int fail_count = 0;
    int cmp_count = 0;

    sdr_top u_dut (
        .clk(clk),
        .rstn(rstn),
        .host_sclk(host_sclk),
        .host_select_n(host_select_n),
        .host_sdi(host_sdi),
        .right_switch(right_switch),
        .left_switch(left_switch),
        .general_input(general_input),
        .actual_position(actual_position),
        .shared_out_irq_pin(shared_out_irq_pin),
        .target_position(target_position),
        .irq(irq),
        .bus_addr(bus_addr),
        .bus_wdata(bus_wdata),
        .bus_wr(bus_wr),
        .bus_rd(bus_rd),
        .bus_rdata(bus_rdata)
    );

    sdr_host_model u_host (
        .sclk(host_sclk),
        .sel_n(host_select_n),
        .sdi(host_sdi),
        .sdo(shared_out_irq_pin)
    );

    // 50 MHz system clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] cmd(input logic ram, input logic [ADDR_BITS-1:0] a,
                                        input logic rd, input logic [23:0] d);
        return {ram, a, rd, d};
    endfunction : cmd

    function automatic logic [7:0] stat(input logic i, r, g, l, t);
        return {i, 1'b0, r, 1'b0, g, 1'b0, l, t};
    endfunction : stat

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    task automatic bus_write(input logic [BUS_AW-1:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask : bus_write

    // Data stand from the cycle after the strobe is taken until the next read
    task automatic bus_read(input logic [BUS_AW-1:0] a, output logic [31:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask : bus_read

    // Conditions in event order; target condition follows the design's target
    task automatic set_cond(input logic [3:0] c);
        @(posedge clk);
        left_switch <= c[EV_LEFT];
        right_switch <= c[EV_RIGHT];
        general_input <= c[EV_GP];
        actual_position <= c[EV_TARGET] ? target_position : ~target_position;
        settle(10);
    endtask : set_cond

    task automatic t_reset();
        logic [31:0] d;
        #1;
        `CHK(shared_out_irq_pin, 1'b1);
        `CHK(irq, 1'b0);
        `CHK(target_position, 24'h0);
        bus_read(BUS_IRQ_ENABLE, d);
        `CHK(d, 32'h0);
        bus_read(8'hFC, d);
        `CHK(d, 32'h0);
    endtask : t_reset

    // Status byte mirrors pin levels captured at frame start
    task automatic t_status();
        logic [31:0] r, d;
        set_cond(4'b1011);
        u_host.frame(cmd(1'b0, SPI_ACTUAL, 1'b1, 24'h0), 32, r);
        `CHK(r[31:24], stat(1'b0, 1'b1, 1'b0, 1'b1, 1'b1));
        set_cond(4'b0110);
        u_host.frame(cmd(1'b0, SPI_CONFIG, 1'b0, 24'h1), 32, r);
        u_host.frame(cmd(1'b0, SPI_CONFIG, 1'b1, 24'h0), 32, r);
        `CHK(r[31:24], stat(1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
        bus_read(BUS_CONFIG, d);
        `CHK(d, 32'h1);
        // Interrupt-only mode hides reply data; the pin stays at the idle interrupt level
        bus_write(BUS_CONFIG, 32'h2);
        u_host.frame(cmd(1'b0, SPI_ACTUAL, 1'b1, 24'h0), 32, r);
        `CHK(r, 32'hFFFFFFFF);
        bus_write(BUS_CONFIG, 32'h0);
    endtask : t_status

    task automatic t_rw();
        logic [31:0] r, d;
        u_host.frame(cmd(1'b0, SPI_TARGET, 1'b0, 24'hA5C3E1), 32, r);
        settle(2);
        `CHK(target_position, 24'hA5C3E1);
        bus_write(BUS_TARGET, 32'h0);
        bus_read(BUS_TARGET, d);
        `CHK(d, 32'h00A5C3E1);
        // Data bits of a read command must be ignored
        u_host.frame(cmd(1'b0, SPI_TARGET, 1'b1, 24'hFFFFFF), 32, r);
        set_cond(4'b1000);
        u_host.frame(cmd(1'b0, SPI_TARGET, 1'b1, 24'h0), 32, r);
        `CHK(r, {stat(1'b0, 1'b0, 1'b0, 1'b0, 1'b1), 24'hA5C3E1});
        u_host.frame(cmd(1'b0, SPI_TARGET, 1'b0, 24'h000111), 31, r);
        settle(2);
        `CHK(target_position, 24'hA5C3E1);
    endtask : t_rw

    // Neighbouring pair location written too, to catch aliasing
    task automatic t_ram();
        logic [31:0] r;
        u_host.frame(cmd(1'b1, 6'h3F, 1'b0, 24'h002321), 32, r);
        u_host.frame(cmd(1'b1, 6'h3E, 1'b0, 24'h000C05), 32, r);
        u_host.frame(cmd(1'b1, 6'h3F, 1'b1, 24'h0), 32, r);
        u_host.frame(cmd(1'b0, SPI_CONFIG, 1'b1, 24'h0), 32, r);
        `CHK(r[13:8], 6'h23);
        `CHK(r[5:0], 6'h21);
    endtask : t_ram

    task automatic t_irq();
        logic [31:0] r, d;
        for (int e = EV_LEFT; e <= EV_TARGET; e++) begin
            set_cond(4'b0000);
            bus_write(BUS_IRQ_CLEAR, 32'h1F);
            bus_write(BUS_IRQ_ENABLE, 32'h0);
            set_cond(4'b0001 << e);
            `CHK(irq, 1'b0);
            bus_read(BUS_IRQ_STATUS, d);
            `CHK(d[e], 1'b1);
            bus_write(BUS_IRQ_ENABLE, 32'h1 << e);
            settle(2);
            `CHK(irq, 1'b1);
            `CHK(shared_out_irq_pin, 1'b0);
            u_host.frame(cmd(1'b0, SPI_ACTUAL, 1'b1, 24'h0), 32, r);
            `CHK(r[31:30], 2'b10);
            bus_write(BUS_IRQ_CLEAR, 32'h1 << e);
            settle(2);
            `CHK(irq, 1'b0);
            `CHK(shared_out_irq_pin, 1'b1);
        end
    endtask : t_irq

    task automatic complete_run();
        $display("comparisons=%0d mismatches=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    // Main sequence
    initial begin
        rstn = 1'b0;
        right_switch = 1'b0;
        left_switch = 1'b0;
        general_input = 1'b0;
        actual_position = '0;
        bus_addr = '0;
        bus_wdata = '0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        settle(4);
        t_status();
        t_rw();
        t_ram();
        t_irq();
        complete_run();
    end

    // Hang guard: whole run needs roughly 95 us
    initial begin
        #1000000;
        fail_count++;
        $display("[ERR] t=%0t watchdog expired", $time);
        complete_run();
    end
endmodule : serial_datagram_status_reply_tb_top
